// File: rtl/msec_pkg.sv
// constants, register map and timing for the misc sense/enable/cascade block
// Behaviour
// RULE1: reset clears every register; the driver holds reset at least 160 ns (the bench's first reset lasts only 100 ns).
// RULE2: internal logic finishes initialising within 960 ns after reset; init_done_o rises 25 cycles (1000 ns) after release.
// RULE3: reset forces mode bit 0 to zero, selecting stopped mode.
// RULE4: sense bit 0 sets when sense input 0 stays asserted 160 ns.
// RULE5: sense bit 1 sets when sense input 1 stays asserted 160 ns.
// RULE6: latched sense bits stay set until cleared by a bus write.
// RULE7: user output 0 follows enable bit 0 of the user register.
// RULE8: user output 1 follows enable bit 1 of the user register.
// RULE9: cascade start is raised only after all devices enable and release ready.
// RULE10: with cascade enabled, ready is released after a JK pair arrives.
// RULE11: sense inputs are synchronised and must be seen on consecutive samples.
// RULE12: user register enable and sense bits read back; enable bits are writable.
package msec_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS  = 40;
  localparam int RST_MIN_NS     = 160;
  localparam int INIT_NS        = 960;
  localparam int SENSE_MIN_NS   = 160;
  // longest time rounds down, least time rounds up
  localparam int INIT_CYC       = INIT_NS / CLK_PERIOD_NS;
  localparam int SENSE_MIN_CYC  =
    (SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_MIN_CYC    =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // control bus geometry
  localparam int ADDR_W         = 5;
  localparam int DATA_W         = 8;

  // register offsets
  localparam logic [4:0] ADDR_MODE    = 5'h00;
  localparam logic [4:0] ADDR_USER_IO = 5'h0F;

  // operating mode register fields
  localparam int MODE_RUN_BIT     = 0;
  localparam int MODE_CASCADE_BIT = 1;
  localparam int MODE_RDY_REL_BIT = 6;
  localparam int MODE_STARTED_BIT = 7;

  // user io register fields
  localparam int UIO_SENSE0_BIT  = 0;
  localparam int UIO_SENSE1_BIT  = 1;
  localparam int UIO_ENABLE0_BIT = 2;
  localparam int UIO_ENABLE1_BIT = 3;

  // reset values and unmapped read data
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] USER_IO_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // control bus cycle states
  typedef enum logic [1:0] {
    MSEC_BUS_INIT,
    MSEC_BUS_IDLE,
    MSEC_BUS_ACKED
  } msec_bus_e;

endpackage

// File: rtl/msec_sense_latch.sv
// one sticky sense input: synchroniser, minimum-width filter and latch
`timescale 1ns/1ps
module msec_sense_latch #(
  parameter int MIN_CYC = 4
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic clr_i,
  output logic      sense_o
);

  localparam int CNT_W = $clog2(MIN_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(MIN_CYC);

  logic             sync1_q;
  logic             sync2_q;
  logic [CNT_W-1:0] run_q;
  logic             set_w;

  // RULE11: two-stage synchroniser
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // RULE11: count consecutive samples
  // the count saturates so a long pulse cannot wrap and re-arm
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= '0;
    end else if (!sync2_q) begin
      run_q <= '0;
    end else if (run_q != CNT_MAX) begin
      run_q <= run_q + CNT_W'(1);
    end
  end

  assign set_w = (run_q == CNT_MAX);

  // RULE6: sticky, set beats clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sense_o <= 1'b0;
    end else if (set_w) begin
      sense_o <= 1'b1;
    end else if (clr_i) begin
      sense_o <= 1'b0;
    end
  end

endmodule

// File: rtl/msec_top.sv
// misc pin logic: reset init, user sense/enable register, cascade ready
`timescale 1ns/1ps
module msec_top
  import msec_pkg::*;
#(
  parameter int SENSE_CYC = msec_pkg::SENSE_MIN_CYC,
  parameter int INIT_CYCLES = msec_pkg::INIT_CYC
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_i,
  // control bus
  input  wire logic                        ce_n_i,
  input  wire logic                        rd_wr_n_i,
  input  wire logic [msec_pkg::ADDR_W-1:0] cba_i,
  input  wire logic [msec_pkg::DATA_W-1:0] cbd_i,
  output logic      [msec_pkg::DATA_W-1:0] cbd_o,
  output logic                             cbd_oe_o,
  output logic                             ack_n_o,
  output logic                             ack_oe_o,
  // user pins
  input  wire logic                        sense_in0_i,
  input  wire logic                        sense_in1_i,
  output logic                             user_out0_o,
  output logic                             user_out1_o,
  // cascade pins and receive path event
  input  wire logic                        cascade_start_i,
  input  wire logic                        jk_pair_i,
  output logic                             cascade_rdy_out_o,
  output logic                             cascade_rdy_out_oe_o,
  // status
  output logic                             run_mode_o,
  output logic                             init_done_o
);

  localparam int INIT_W = $clog2(INIT_CYCLES + 1);
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES);

  msec_bus_e   bus_q;
  logic [INIT_W-1:0] init_cnt_q;
  logic [7:0]  mode_q;
  logic        enable0_q;
  logic        enable1_q;
  logic        rdy_released_q;
  logic        started_q;
  logic        sense0_w;
  logic        sense1_w;
  logic        clr0_w;
  logic        clr1_w;
  logic        take_w;
  logic        wr_w;
  logic [7:0]  rd_mux_w;
  logic [7:0]  mode_view_w;
  logic [7:0]  uio_view_w;

  // RULE2: init counter after reset release
  // the bus is deaf until it expires, so early cycles never half-complete
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt_q <= '0;
    end else if (init_cnt_q != INIT_LAST) begin
      init_cnt_q <= init_cnt_q + INIT_W'(1);
    end
  end

  // RULE2: init done flag
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      init_done_o <= 1'b0;
    end else begin
      init_done_o <= (init_cnt_q == INIT_LAST);
    end
  end

  // a cycle is taken once per chip-enable low period
  assign take_w = (bus_q == MSEC_BUS_IDLE) && !ce_n_i;
  assign wr_w   = take_w && !rd_wr_n_i;

  // control bus cycle sequencer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q <= MSEC_BUS_INIT;
    end else begin
      case (bus_q)
        MSEC_BUS_INIT: begin
          if (init_done_o) begin
            bus_q <= MSEC_BUS_IDLE;
          end
        end
        MSEC_BUS_IDLE: begin
          if (!ce_n_i) begin
            bus_q <= MSEC_BUS_ACKED;
          end
        end
        MSEC_BUS_ACKED: begin
          if (ce_n_i) begin
            bus_q <= MSEC_BUS_IDLE;
          end
        end
        default: begin
          bus_q <= MSEC_BUS_INIT;
        end
      endcase
    end
  end

  // acknowledge held low while chip enable stays low
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_oe_o <= 1'b0;
      ack_n_o  <= 1'b0;
    end else begin
      ack_n_o <= 1'b0; // open drain: only ever pulls low
      if (take_w) begin
        ack_oe_o <= 1'b1;
      end else if (ce_n_i) begin
        ack_oe_o <= 1'b0;
      end
    end
  end

  // readback views of the two registers
  always_comb begin
    mode_view_w = mode_q;
    mode_view_w[MODE_RDY_REL_BIT] = rdy_released_q;
    mode_view_w[MODE_STARTED_BIT] = started_q;
    uio_view_w = 8'h00;
    uio_view_w[UIO_SENSE0_BIT]  = sense0_w;
    uio_view_w[UIO_SENSE1_BIT]  = sense1_w;
    uio_view_w[UIO_ENABLE0_BIT] = enable0_q;
    uio_view_w[UIO_ENABLE1_BIT] = enable1_q;
  end

  // RULE12: read address decode
  always_comb begin
    case (cba_i)
      ADDR_MODE:    rd_mux_w = mode_view_w;
      ADDR_USER_IO: rd_mux_w = uio_view_w;
      default:      rd_mux_w = RDATA_UNMAPPED;
    endcase
  end

  // read data captured at the taking edge, driven while acked
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cbd_o    <= 8'h00;
      cbd_oe_o <= 1'b0;
    end else if (take_w) begin
      cbd_o    <= rd_mux_w;
      cbd_oe_o <= rd_wr_n_i;
    end else if (ce_n_i) begin
      cbd_oe_o <= 1'b0;
    end
  end

  // RULE1: registers cleared by reset
  // RULE3: mode bit 0 forced to stop
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= MODE_RESET;
    end else if (wr_w && (cba_i == ADDR_MODE)) begin
      mode_q <= cbd_i;
      // status bits live elsewhere and read through the view
      mode_q[MODE_RDY_REL_BIT] <= 1'b0;
      mode_q[MODE_STARTED_BIT] <= 1'b0;
    end
  end

  assign run_mode_o = mode_q[MODE_RUN_BIT];

  // RULE12: enable bits writable
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      enable0_q <= USER_IO_RESET[UIO_ENABLE0_BIT];
      enable1_q <= USER_IO_RESET[UIO_ENABLE1_BIT];
    end else if (wr_w && (cba_i == ADDR_USER_IO)) begin
      enable0_q <= cbd_i[UIO_ENABLE0_BIT];
      enable1_q <= cbd_i[UIO_ENABLE1_BIT];
    end
  end

  // RULE7: user output 0 pin
  // RULE8: user output 1 pin
  // one extra flop keeps the pins glitch free
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      user_out0_o <= 1'b0;
      user_out1_o <= 1'b0;
    end else begin
      user_out0_o <= enable0_q;
      user_out1_o <= enable1_q;
    end
  end

  // RULE6: writing zero to a sense bit clears it
  assign clr0_w = wr_w && (cba_i == ADDR_USER_IO) && !cbd_i[UIO_SENSE0_BIT];
  assign clr1_w = wr_w && (cba_i == ADDR_USER_IO) && !cbd_i[UIO_SENSE1_BIT];

  // RULE4: sense input 0 latch
  msec_sense_latch #(
    .MIN_CYC (SENSE_CYC)
  ) u_sense0 (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (sense_in0_i),
    .clr_i   (clr0_w),
    .sense_o (sense0_w)
  );

  // RULE5: sense input 1 latch
  msec_sense_latch #(
    .MIN_CYC (SENSE_CYC)
  ) u_sense1 (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   (sense_in1_i),
    .clr_i   (clr1_w),
    .sense_o (sense1_w)
  );

  // RULE10: release ready after JK pair
  // leaving cascade mode re-arms, so a later entry waits for a fresh JK
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_released_q <= 1'b0;
    end else if (!mode_q[MODE_CASCADE_BIT]) begin
      rdy_released_q <= 1'b0;
    end else if (jk_pair_i) begin
      rdy_released_q <= 1'b1;
    end
  end

  // RULE9: start only counts once released
  // the pin is trusted as synchronous; a start seen early is ignored
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      started_q <= 1'b0;
    end else if (!mode_q[MODE_CASCADE_BIT]) begin
      started_q <= 1'b0;
    end else if (cascade_start_i && rdy_released_q) begin
      started_q <= 1'b1;
    end
  end

  // open-drain ready: pulled low until released
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cascade_rdy_out_o    <= 1'b0;
      cascade_rdy_out_oe_o <= 1'b1;
    end else begin
      cascade_rdy_out_o    <= 1'b0;
      cascade_rdy_out_oe_o <= !rdy_released_q;
    end
  end

endmodule

// File: verif/msec_properties.sv
// port assertions for the misc sense/enable/cascade block
`timescale 1ns/1ps
module msec_properties
  import msec_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic              ce_n_i,
  input wire logic              rd_wr_n_i,
  input wire logic [ADDR_W-1:0] cba_i,
  input wire logic [DATA_W-1:0] cbd_i,
  input wire logic              ack_oe_o,
  input wire logic              user_out0_o,
  input wire logic              user_out1_o,
  input wire logic              jk_pair_i,
  input wire logic              cascade_rdy_out_oe_o,
  input wire logic              run_mode_o,
  input wire logic              init_done_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // a write to the user register with its ack just raised
  sequence uio_wr_s;
    $rose(ack_oe_o) && !rd_wr_n_i && cba_i == ADDR_USER_IO;
  endsequence

  ack_rise_a: assert property ($rose(ack_oe_o) |-> !$past(ce_n_i))
    else $error("ack raised without chip enable");
  ack_hold_a: assert property (ack_oe_o && !ce_n_i |=> ack_oe_o)
    else $error("ack dropped while chip enable low");
  ack_drop_a: assert property (ack_oe_o && ce_n_i |=> !ack_oe_o)
    else $error("ack held after chip enable high");
  init_quiet_a: assert property (!init_done_o |-> !ack_oe_o)
    else $error("bus answered during init");
  stop_init_a: assert property (!init_done_o |-> !run_mode_o)
    else $error("run mode set before init done");
  out0_follow_a: assert property (
    uio_wr_s |=> user_out0_o == $past(cbd_i[UIO_ENABLE0_BIT]))
    else $error("user out 0 not following enable");
  out1_follow_a: assert property (
    uio_wr_s |=> user_out1_o == $past(cbd_i[UIO_ENABLE1_BIT]))
    else $error("user out 1 not following enable");
  rdy_release_a: assert property ($fell(cascade_rdy_out_oe_o) |->
    $past(jk_pair_i) || $past(jk_pair_i, 2) || $past(jk_pair_i, 3))
    else $error("ready released without jk pair");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |->
    cascade_rdy_out_oe_o && !user_out0_o && !user_out1_o && !ack_oe_o)
    else $error("outputs not cleared in reset");

  // main scenarios reached
  cover property ($rose(ack_oe_o));
  cover property ($fell(cascade_rdy_out_oe_o));
  cover property ($rose(user_out1_o));
endmodule

bind msec_top msec_properties u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .ce_n_i(ce_n_i), .rd_wr_n_i(rd_wr_n_i), .cba_i(cba_i), .cbd_i(cbd_i),
  .ack_oe_o(ack_oe_o), .user_out0_o(user_out0_o),
  .user_out1_o(user_out1_o), .jk_pair_i(jk_pair_i),
  .cascade_rdy_out_oe_o(cascade_rdy_out_oe_o), .run_mode_o(run_mode_o),
  .init_done_o(init_done_o));

// File: verif/msec_peer.sv
// cascaded peer model: drives the shared start line
`timescale 1ns/1ps
module msec_peer (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic arm_i,
  input  wire logic rdy_wire_i,
  output logic      start_o
);
  // start after release
  // arm stands for all peers enabled; the wire is the wired-and of ready
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start_o <= 1'b0;
    end else begin
      start_o <= arm_i && rdy_wire_i;
    end
  end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the misc sense/enable/cascade block
`timescale 1ns/1ps
module tb_top;
  import msec_pkg::*;
  localparam int INIT_C = 2;
  // reset rises just after time zero so every flop clears before edge one
  logic       mclk_i = 0, rst_i = 0, ce_n_i = 1, rd_wr_n_i = 1;
  logic       jk_pair_i = 0, sense_in0_i = 0, sense_in1_i = 0, arm = 0;
  logic [4:0] cba_i = 5'h00;
  logic [7:0] cbd_i = 8'h00, cbd_o, d;
  logic       cbd_oe_o, ack_n_o, ack_oe_o, user_out0_o, user_out1_o;
  logic       cascade_start_i, cascade_rdy_out_o, cascade_rdy_out_oe_o;
  logic       run_mode_o, init_done_o, rdy_wire, rd_seen = 0;
  logic [7:0] exp_q[$];
  int         err_count = 0, comparisons = 0, cyc = 0, seed = 88351;

  always #20 mclk_i = ~mclk_i;
  // ready line has a pull-up; only the device pulls it low
  assign rdy_wire = cascade_rdy_out_oe_o ? cascade_rdy_out_o : 1'b1;

  msec_top #(.INIT_CYCLES(INIT_C)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .ce_n_i(ce_n_i), .rd_wr_n_i(rd_wr_n_i), .cba_i(cba_i), .cbd_i(cbd_i),
    .cbd_o(cbd_o), .cbd_oe_o(cbd_oe_o), .ack_n_o(ack_n_o),
    .ack_oe_o(ack_oe_o), .sense_in0_i(sense_in0_i),
    .sense_in1_i(sense_in1_i), .user_out0_o(user_out0_o),
    .user_out1_o(user_out1_o), .cascade_start_i(cascade_start_i),
    .jk_pair_i(jk_pair_i), .cascade_rdy_out_o(cascade_rdy_out_o),
    .cascade_rdy_out_oe_o(cascade_rdy_out_oe_o), .run_mode_o(run_mode_o),
    .init_done_o(init_done_o));
  msec_peer u_peer (.mclk_i(mclk_i), .rst_i(rst_i), .arm_i(arm),
    .rdy_wire_i(rdy_wire), .start_o(cascade_start_i));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic close_out;
    // a read note never answered means a data phase went missing
    if (exp_q.size() != 0) err_count++;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // steps n edges, then settles just past the last one
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // one bus cycle; reads note the expected byte for the monitor
  task automatic bus(input logic rw, input logic [4:0] a,
                     input logic [7:0] dat);
    int n;
    n = 0;
    if (rw) exp_q.push_back(dat);
    step(1);
    ce_n_i = 0;
    rd_wr_n_i = rw;
    cba_i = a;
    cbd_i = dat;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack_oe_o !== 1'b1 && n < 60);
    if (n == 60) err_count++;
    #1;
    chk(ack_n_o, 1'b0);
    ce_n_i = 1;
    cbd_i = ~cbd_i;
    // leave just past the edge so the next stimulus never races it
    step(1);
  endtask

  // read data monitor: first edge of each data phase takes one note
  always @(posedge mclk_i) begin
    if (cbd_oe_o === 1'b1 && !rd_seen) begin
      if (exp_q.size() == 0) err_count++;
      else cmp8(cbd_o, exp_q.pop_front());
    end
    rd_seen <= (cbd_oe_o === 1'b1);
  end

  // hang guard, well above the expected run length
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      close_out;
    end
  end

  initial begin
    #1;
    rst_i = 1;
    step(3);
    rst_i = 0;
    step(INIT_C + 3);
    chk(init_done_o, 1'b1);
    chk(run_mode_o, 1'b0);
    bus(1, ADDR_MODE, MODE_RESET);
    bus(1, ADDR_USER_IO, USER_IO_RESET);
    bus(0, ADDR_MODE, 8'h01);
    chk(run_mode_o, 1'b1);
    bus(1, 5'h1A, RDATA_UNMAPPED);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      d[3:0] = {i[1:0], 2'b11};
      bus(0, ADDR_USER_IO, d);
      chk(user_out0_o, d[2]);
      chk(user_out1_o, d[3]);
      bus(1, ADDR_USER_IO, d & 8'h0C);
    end
    bus(0, 5'h1A, 8'hFF);
    bus(1, ADDR_USER_IO, 8'h0C);
    sense_in0_i = 1;
    step(1);
    sense_in0_i = 0;
    step(10);
    bus(1, ADDR_USER_IO, 8'h0C);
    sense_in1_i = 1;
    step(8);
    sense_in1_i = 0;
    step(4);
    bus(1, ADDR_USER_IO, 8'h0E);
    sense_in0_i = 1;
    step(8);
    sense_in0_i = 0;
    step(4);
    bus(1, ADDR_USER_IO, 8'h0F);
    bus(0, ADDR_USER_IO, 8'h0D);
    bus(1, ADDR_USER_IO, 8'h0D);
    bus(0, ADDR_MODE, 8'h03);
    arm = 1;
    step(1);
    jk_pair_i = 1;
    step(1);
    jk_pair_i = 0;
    step(3);
    chk(rdy_wire, 1'b1);
    step(2);
    bus(1, ADDR_MODE, 8'hC3);
    bus(0, ADDR_MODE, 8'h01);
    step(2);
    chk(rdy_wire, 1'b0);
    arm = 0;
    rst_i = 1;
    // mid-run reset keeps the system minimum width
    step(RST_MIN_CYC);
    chk(user_out0_o, 1'b0);
    rst_i = 0;
    step(INIT_C + 3);
    bus(1, ADDR_USER_IO, USER_IO_RESET);
    bus(1, ADDR_MODE, MODE_RESET);
    close_out;
  end
endmodule
